// ---- rtl/hpp_regs.svh ----
`ifndef HPP_REGS_SVH
`define HPP_REGS_SVH

// ============================================================
// Register byte offsets
`define HPP_ADDR_CTRL      8'h00
`define HPP_ADDR_EEPROM    8'h04
`define HPP_ADDR_STATUS    8'h08
`define HPP_ADDR_IRQ_STAT  8'h0c
`define HPP_ADDR_IRQ_MASK  8'h10

// ============================================================
// Field positions
`define HPP_CTRL_PWR_LSB   0
`define HPP_CTRL_SUSP_BIT  4
`define HPP_EE_CLK_BIT     0
`define HPP_EE_DOUT_BIT    1
`define HPP_EE_DOE_BIT     2
`define HPP_EE_DIN_BIT     3
`define HPP_ST_OC_LSB      0
`define HPP_ST_PWR_LSB     4
`define HPP_ST_EXTERNAL_MEMORY_STRAP_BIT  8
`define HPP_ST_GANGED_BIT  9
`define HPP_ST_CLKSRC_BIT  10

// ============================================================
// Reset values
`define HPP_CTRL_RST       5'h00
`define HPP_EE_RST         3'h0
`define HPP_MASK_RST       4'h0

// ============================================================
// Timing
`define HPP_CLK_MHZ        250
`define HPP_OC_FILT_NS     1000
`define HPP_OC_FILT_CYC    ((`HPP_OC_FILT_NS * `HPP_CLK_MHZ) / 1000)
`define HPP_STRAP_SETTLE   2'h3

`endif

// ---- rtl/hpp_pkg.sv ----
`default_nettype none

package hpp_pkg;
  typedef logic [3:0] hpp_port_t;
  typedef enum logic [0:0] {
    HPP_SETTLE,
    HPP_RUN
  } hpp_state_e;
endpackage : hpp_pkg

`default_nettype wire

// ---- rtl/hpp_port_power.sv ----
`include "hpp_regs.svh"
`default_nettype none

module hpp_port_power (
  input  wire logic               i_clk_sys,
  input  wire logic               i_arst_n,
  input  wire logic [7:0]         i_address,
  input  wire logic               i_read,
  input  wire logic               i_write,
  input  wire logic [3:0]         i_byteenable,
  input  wire logic [31:0]        i_writedata,
  output logic      [31:0]        o_readdata,
  output logic                    o_waitrequest,
  output logic                    o_irq,
  input  wire logic               i_external_memory_strap,
  input  wire logic               i_clock_source_strap,
  input  wire hpp_pkg::hpp_port_t i_port_overcurrent_n,
  output hpp_pkg::hpp_port_t      o_port_power_enable_n,
  output logic                    o_suspend_status_out,
  output logic                    o_eeprom_serial_clock_out,
  output logic                    o_eeprom_serial_clock_oe_n,
  input  wire logic               i_shared_data_or_power_group_pin,
  output logic                    o_shared_data_or_power_group_pin,
  output logic                    o_shared_data_or_power_group_oe_n,
  output logic                    o_pll_enable,
  output logic                    o_osc_enable
);
  import hpp_pkg::*;

  // ============================================================
  // Declarations
  logic [1:0]  external_memory_strap_sync_reg;
  logic [1:0]  clksrc_sync_reg;
  logic [1:0]  shared_sync_reg;
  hpp_port_t   oc_meta_reg;
  hpp_port_t   oc_sync_reg;
  logic [8:0]  oc_cnt_reg [4];
  hpp_port_t   oc_filt_reg;
  hpp_port_t   oc_filt_next;
  hpp_port_t   oc_rise;
  hpp_state_e  state_reg;
  logic [1:0]  settle_reg;
  logic        external_memory_strap_reg;
  logic        clksrc_reg;
  logic        ganged_reg;
  logic [4:0]  ctrl_reg;
  logic [2:0]  ee_reg;
  hpp_port_t   irq_mask_reg;
  hpp_port_t   irq_stat_reg;
  hpp_port_t   pwr_on;
  logic        wait_reg;
  logic        take_wr;
  logic        take_rd;
  logic [31:0] rd_next;

  // Index-free full-width equality check of a byte address against a register offset
  function automatic logic hpp_hit(input logic [7:0] addr, input logic [7:0] offs);
    hpp_hit = (addr == offs);
  endfunction : hpp_hit

  // ============================================================
  // Pin synchronisers
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      external_memory_strap_sync_reg <= 2'h3;
      clksrc_sync_reg <= 2'h0;
      shared_sync_reg <= 2'h0;
      oc_meta_reg     <= 4'hf;
      oc_sync_reg     <= 4'hf;
    end else begin
      external_memory_strap_sync_reg <= {external_memory_strap_sync_reg[0], i_external_memory_strap};
      clksrc_sync_reg <= {clksrc_sync_reg[0], i_clock_source_strap};
      shared_sync_reg <= {shared_sync_reg[0], i_shared_data_or_power_group_pin};
      oc_meta_reg     <= i_port_overcurrent_n;
      oc_sync_reg     <= oc_meta_reg;
    end
  end

  // ============================================================
  // Strap capture after reset release
  // Straps are caught once; the select must not move while running
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg  <= HPP_SETTLE;
      settle_reg <= 2'h0;
      external_memory_strap_reg <= 1'b1;
      clksrc_reg <= 1'b0;
      ganged_reg <= 1'b0;
    end else begin
      case (state_reg)
        HPP_SETTLE: begin
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == `HPP_STRAP_SETTLE) begin
            external_memory_strap_reg <= external_memory_strap_sync_reg[1];
            clksrc_reg <= clksrc_sync_reg[1];
            ganged_reg <= external_memory_strap_sync_reg[1] & shared_sync_reg[1];
            state_reg  <= HPP_RUN;
          end
        end
        HPP_RUN: begin
          state_reg <= HPP_RUN;
        end
        default: begin
          state_reg <= HPP_SETTLE;
        end
      endcase
    end
  end

  // ============================================================
  // Overcurrent filter
  // Any high sample restarts the count, so a fault must be low for the whole window
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 4; i++) begin
        oc_cnt_reg[i] <= 9'h000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (oc_sync_reg[i]) begin
          oc_cnt_reg[i] <= 9'h000;
        end else if (oc_cnt_reg[i] != 9'(`HPP_OC_FILT_CYC)) begin
          oc_cnt_reg[i] <= oc_cnt_reg[i] + 9'h001;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      oc_filt_next[i] = (oc_cnt_reg[i] == 9'(`HPP_OC_FILT_CYC));
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oc_filt_reg <= 4'h0;
    end else begin
      oc_filt_reg <= oc_filt_next;
    end
  end

  assign oc_rise = oc_filt_next & ~oc_filt_reg;

  // ============================================================
  // Port power
  always_comb begin
    if (state_reg != HPP_RUN) begin
      pwr_on = 4'h0;
    end else if (ganged_reg) begin
      pwr_on = (ctrl_reg[`HPP_CTRL_PWR_LSB] && !(|oc_filt_next)) ? 4'hf : 4'h0;
    end else begin
      pwr_on = ctrl_reg[`HPP_CTRL_PWR_LSB +: 4] & ~oc_filt_next;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_port_power_enable_n <= 4'hf;
    end else begin
      o_port_power_enable_n <= ~pwr_on;
    end
  end

  // ============================================================
  // Serial memory pins, clock source and suspend
  // Outputs of the pin group are registered; enables are low while driving
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_eeprom_serial_clock_out         <= 1'b0;
      o_eeprom_serial_clock_oe_n        <= 1'b1;
      o_shared_data_or_power_group_pin  <= 1'b0;
      o_shared_data_or_power_group_oe_n <= 1'b1;
      o_pll_enable                      <= 1'b0;
      o_osc_enable                      <= 1'b0;
      o_suspend_status_out              <= 1'b0;
    end else begin
      o_eeprom_serial_clock_out         <= !external_memory_strap_reg && ee_reg[`HPP_EE_CLK_BIT];
      o_eeprom_serial_clock_oe_n        <= external_memory_strap_reg;
      o_shared_data_or_power_group_pin  <= !external_memory_strap_reg && ee_reg[`HPP_EE_DOUT_BIT];
      o_shared_data_or_power_group_oe_n <= external_memory_strap_reg || !ee_reg[`HPP_EE_DOE_BIT];
      o_pll_enable                      <= (state_reg == HPP_RUN) && !clksrc_reg;
      o_osc_enable                      <= (state_reg == HPP_RUN) && !clksrc_reg;
      o_suspend_status_out              <= ctrl_reg[`HPP_CTRL_SUSP_BIT];
    end
  end

  // ============================================================
  // Avalon-MM slave
  // Every access waits one cycle, then completes with waitrequest low for one cycle
  assign take_wr = i_write && !wait_reg;
  assign take_rd = i_read && !wait_reg;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_reg <= 1'b1;
    end else if ((i_read || i_write) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign o_waitrequest = wait_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (hpp_hit(i_address, `HPP_ADDR_CTRL)) begin
      rd_next[4:0] = ctrl_reg;
    end else if (hpp_hit(i_address, `HPP_ADDR_EEPROM)) begin
      rd_next[2:0] = ee_reg;
      rd_next[`HPP_EE_DIN_BIT] = shared_sync_reg[1];
    end else if (hpp_hit(i_address, `HPP_ADDR_STATUS)) begin
      rd_next[`HPP_ST_OC_LSB +: 4]  = oc_filt_reg;
      rd_next[`HPP_ST_PWR_LSB +: 4] = ~o_port_power_enable_n;
      rd_next[`HPP_ST_EXTERNAL_MEMORY_STRAP_BIT]   = external_memory_strap_reg;
      rd_next[`HPP_ST_GANGED_BIT]   = ganged_reg;
      rd_next[`HPP_ST_CLKSRC_BIT]   = clksrc_reg;
    end else if (hpp_hit(i_address, `HPP_ADDR_IRQ_STAT)) begin
      rd_next[3:0] = irq_stat_reg;
    end else if (hpp_hit(i_address, `HPP_ADDR_IRQ_MASK)) begin
      rd_next[3:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && wait_reg) begin
      o_readdata <= rd_next;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg     <= `HPP_CTRL_RST;
      ee_reg       <= `HPP_EE_RST;
      irq_mask_reg <= `HPP_MASK_RST;
    end else if (take_wr && i_byteenable[0]) begin
      if (hpp_hit(i_address, `HPP_ADDR_CTRL)) begin
        ctrl_reg <= i_writedata[4:0];
      end
      if (hpp_hit(i_address, `HPP_ADDR_EEPROM)) begin
        ee_reg <= i_writedata[2:0];
      end
      if (hpp_hit(i_address, `HPP_ADDR_IRQ_MASK)) begin
        irq_mask_reg <= i_writedata[3:0];
      end
    end
  end

  // ============================================================
  // Interrupts
  // Only the bits returned by the read are cleared, and a new trip wins
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_reg <= 4'h0;
    end else if (take_rd && hpp_hit(i_address, `HPP_ADDR_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~o_readdata[3:0]) | oc_rise;
    end else begin
      irq_stat_reg <= irq_stat_reg | oc_rise;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule : hpp_port_power

`default_nettype wire

// ---- test/hpp_switch_model.sv ----
`default_nettype none
// ============================================================
// Power switches and board straps
module hpp_switch_model (
  input  wire logic       i_ext_strap,
  input  wire logic       i_group_lvl,
  input  wire logic [3:0] i_fault,
  input  wire logic       i_dout,
  input  wire logic       i_doe_n,
  output logic      [3:0] o_oc_n,
  output logic            o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // A ganged board ties all fault lines, so one trip pulls every input low
  assign o_oc_n = (i_ext_strap && i_group_lvl) ? {4{~|i_fault}} : ~i_fault;
  // Grouping level is a fixed strap; a released data line falls to its pull-down
  assign o_pin = i_ext_strap ? i_group_lvl : (!i_doe_n && i_dout);
endmodule : hpp_switch_model
`default_nettype wire

// ---- test/hpp_port_power_checker.sv ----
`default_nettype none
// ============================================================
// Pin checker
module hpp_port_power_checker (
  input wire logic               i_clk_sys,
  input wire logic               i_arst_n,
  input wire logic               i_write,
  input wire logic               i_external_memory_strap,
  input wire logic               i_clock_source_strap,
  input wire logic               i_shared_data_or_power_group_pin,
  input wire hpp_pkg::hpp_port_t i_port_overcurrent_n,
  input wire hpp_pkg::hpp_port_t o_port_power_enable_n,
  input wire logic               o_suspend_status_out,
  input wire logic               o_eeprom_serial_clock_out,
  input wire logic               o_eeprom_serial_clock_oe_n,
  input wire logic               o_shared_data_or_power_group_oe_n,
  input wire logic               o_pll_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import hpp_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic [3:0] run_cnt_reg;
  // Straps are captured a few edges after reset, so the memory-clock drive and clock-source checks wait
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) run_cnt_reg <= 4'h0;
    else if (run_cnt_reg != 4'hf) run_cnt_reg <= run_cnt_reg + 4'h1;
  end
  for (genvar g = 0; g < 4; g++) begin : g_port
    logic [8:0] low_cnt_reg;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) low_cnt_reg <= 9'h000;
      else if (i_port_overcurrent_n[g]) low_cnt_reg <= 9'h000;
      else if (low_cnt_reg != 9'h1ff) low_cnt_reg <= low_cnt_reg + 9'h001;
    end
    // Sync, 250-cycle filter and output register all fit inside 260 cycles
    a_fault_cuts_power: assert property (low_cnt_reg == 9'h104 |-> o_port_power_enable_n[g])
      else $error("power kept on through held fault");
  end
  a_clk_released: assert property (i_external_memory_strap |-> o_eeprom_serial_clock_oe_n && !o_eeprom_serial_clock_out)
    else $error("memory clock driven");
  a_clk_driven: assert property (run_cnt_reg == 4'hf && !i_external_memory_strap |-> !o_eeprom_serial_clock_oe_n)
    else $error("memory clock released");
  a_group_input: assert property (i_external_memory_strap |-> o_shared_data_or_power_group_oe_n)
    else $error("grouping pin driven");
  a_ganged_together: assert property (i_external_memory_strap && i_shared_data_or_power_group_pin |-> o_port_power_enable_n inside {4'h0, 4'hf})
    else $error("ganged enables split");
  a_suspend_cause: assert property ($rose(o_suspend_status_out) |-> $past(i_write) || $past(i_write, 2))
    else $error("suspend rose without write");
  a_pll_select: assert property (run_cnt_reg == 4'hf |-> o_pll_enable == !i_clock_source_strap)
    else $error("clock source wrong");
  a_reset_init: assert property ($rose(i_arst_n) |-> o_port_power_enable_n == 4'hf && !o_suspend_status_out)
    else $error("outputs not initialised");
endmodule : hpp_port_power_checker

bind hpp_port_power hpp_port_power_checker chk_u (.i_clk_sys, .i_arst_n, .i_write, .i_external_memory_strap,
  .i_clock_source_strap, .i_shared_data_or_power_group_pin, .i_port_overcurrent_n, .o_port_power_enable_n,
  .o_suspend_status_out, .o_eeprom_serial_clock_out, .o_eeprom_serial_clock_oe_n,
  .o_shared_data_or_power_group_oe_n, .o_pll_enable);
`default_nettype wire

// ---- test/tb_hpp_port_power.sv ----
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("wrong value t=%0t %h/%h", $time, g, e); end end
// ============================================================
// Bench
module tb_hpp_port_power;
  timeunit 1ns;
  timeprecision 1ps;
  import hpp_pkg::*;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, ext = 0, csrc = 0, grp = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0, rdo, rdata;
  hpp_port_t   fault = 4'h0, oc_n, en_n;
  logic        wt, irq, susp, cko, ckoe, dout, doe, pin, pll, osc;
  int          fail_count = 0, compares = 0, ctrl;
  integer      seed = 32'h7e77;
  initial forever #2 clk = ~clk;
  hpp_port_power dut_u (.i_clk_sys(clk), .i_arst_n(rst_n), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_byteenable(4'hf), .i_writedata(wd), .o_readdata(rdo), .o_waitrequest(wt), .o_irq(irq),
    .i_external_memory_strap(ext), .i_clock_source_strap(csrc), .i_port_overcurrent_n(oc_n),
    .o_port_power_enable_n(en_n), .o_suspend_status_out(susp), .o_eeprom_serial_clock_out(cko),
    .o_eeprom_serial_clock_oe_n(ckoe), .i_shared_data_or_power_group_pin(pin),
    .o_shared_data_or_power_group_pin(dout), .o_shared_data_or_power_group_oe_n(doe),
    .o_pll_enable(pll), .o_osc_enable(osc));
  hpp_switch_model sw_u (.i_ext_strap(ext), .i_group_lvl(grp), .i_fault(fault), .i_dout(dout),
    .i_doe_n(doe), .o_oc_n(oc_n), .o_pin(pin));
  function automatic hpp_port_t exp_en(input int c, input int f, input bit g);
    if (g) return ((c & 1) != 0 && f == 0) ? 4'h0 : 4'hf;
    return ~(c[3:0] & ~f[3:0]);
  endfunction : exp_en
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 99);
    rdata = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (n == 99) fail_count++;
  endtask : bus
  task automatic restart(input logic e, input logic g, input logic c);
    rst_n <= 1'b0;
    ext <= e;
    grp <= g;
    csrc <= c;
    // Reset is far shorter than on a board to keep the run short; the clock runs throughout
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (9) @(posedge clk);
    `CHK({en_n, susp}, 5'h1e)
  endtask : restart
  task automatic results;
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    #100000;
    fail_count++;
    results();
  end
  initial begin
    restart(1'b0, 1'b0, 1'b0);
    `CHK({ckoe, pll, osc}, 3'b011)
    bus(1'b1, 8'h14, 32'hff);
    bus(1'b0, 8'h14, 32'h0);
    for (int i = 0; i < 6; i++) begin
      ctrl = $random(seed) & 31;
      bus(1'b1, 8'h00, ctrl);
      repeat (2) @(posedge clk);
      `CHK(en_n, exp_en(ctrl, 0, 0))
      `CHK(susp, ctrl[4])
    end
    $display("test power request done");
    bus(1'b1, 8'h00, 32'hf);
    bus(1'b1, 8'h10, 32'h4);
    fault <= 4'h4;
    repeat (300) @(posedge clk);
    `CHK({en_n, irq}, {exp_en(15, 4, 0), 1'b1})
    bus(1'b0, 8'h0c, 32'h0);
    repeat (2) @(posedge clk);
    `CHK({rdata[3:0], irq}, 5'h08)
    fault <= 4'h0;
    repeat (10) @(posedge clk);
    // Spike well short of the filter time must leave power alone
    fault <= 4'h2;
    repeat (100) @(posedge clk);
    fault <= 4'h0;
    repeat (10) @(posedge clk);
    `CHK(en_n, 4'h0)
    $display("test overcurrent done");
    bus(1'b1, 8'h04, 32'h7);
    repeat (3) @(posedge clk);
    bus(1'b0, 8'h04, 32'h0);
    `CHK({rdata[3:0], cko, dout, doe}, 7'h7e)
    $display("test serial pins done");
    restart(1'b1, 1'b1, 1'b1);
    `CHK({ckoe, doe, pll}, 3'b110)
    bus(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(en_n, exp_en(1, 0, 1))
    fault <= 4'h1;
    repeat (300) @(posedge clk);
    `CHK(en_n, exp_en(1, 1, 1))
    bus(1'b0, 8'h08, 32'h0);
    `CHK(rdata[10:8], 3'h7)
    $display("test ganged done");
    results();
  end
endmodule : tb_hpp_port_power
`default_nettype wire
